// File: include/aeg_pkg.sv
// package: constants and types for the addressing mode / address generator
//
// Behaviour
// - Ten operand addressing modes are decoded from the opcode.
// - Immediate operand is the byte after opcode; address is PC+1; two bytes.
// - Direct address is the second byte with upper byte zero.
// - Extended address is the two bytes after opcode; three bytes long.
// - Relative mode is only for branches; two bytes, one displacement byte.
// - Taken branch target is instruction address plus 2 plus signed displacement.
// - A branch not taken uses zero displacement and falls through.
// - Indexed no offset address is index zero-extended; one byte long.
// - Indexed 8-bit offset is unsigned offset plus index; two bytes long.
// - Indexed 16-bit offset is two-byte offset plus index; three bytes long.
// - Bit set/clear: byte after opcode is page-zero address, opcode picks bit.
// - Bit test: second byte addresses page zero, third is displacement.
// - Bit test copies the tested bit into carry, taken or not.
// - Implied mode has no effective address and is one byte long.
// - Set/clear act on page-zero RAM and I/O but not direction registers.
// - Bit test reaches all of page zero, ROM included.
// - Write-back of a control register returns the bit 7 value read, except when the opcode selects bit 7, which is forced.
// - Bit test opcode is 2n for branch-if-set, 01+2n for branch-if-clear.
package aeg_pkg;

	localparam int          AEG_AW        = 16;
	localparam logic [7:0]  AEG_PAGE_ZERO = 8'h00;
	localparam logic [15:0] AEG_REL_BASE  = 16'h0002;
	localparam logic [15:0] AEG_BTB_BASE  = 16'h0003;
	localparam int          AEG_SIGN_BIT  = 7;
	localparam int          AEG_FLAG_BIT  = 7;

	// instruction lengths in bytes
	localparam logic [1:0]  AEG_LEN1 = 2'h1;
	localparam logic [1:0]  AEG_LEN2 = 2'h2;
	localparam logic [1:0]  AEG_LEN3 = 2'h3;

	// opcode upper nibble groups and the full BSR opcode
	localparam logic [3:0]  AEG_OP_BTB  = 4'h0;
	localparam logic [3:0]  AEG_OP_BSC  = 4'h1;
	localparam logic [3:0]  AEG_OP_REL  = 4'h2;
	localparam logic [3:0]  AEG_OP_DIRM = 4'h3;
	localparam logic [3:0]  AEG_OP_IDX1 = 4'h6;
	localparam logic [3:0]  AEG_OP_IDX0 = 4'h7;
	localparam logic [3:0]  AEG_OP_IMM  = 4'hA;
	localparam logic [3:0]  AEG_OP_DIR  = 4'hB;
	localparam logic [3:0]  AEG_OP_EXT  = 4'hC;
	localparam logic [3:0]  AEG_OP_IDX2 = 4'hD;
	localparam logic [3:0]  AEG_OP_IDX1B = 4'hE;
	localparam logic [3:0]  AEG_OP_IDX0B = 4'hF;
	localparam logic [7:0]  AEG_OP_BSR  = 8'hAD;

	// default page-zero addresses of protected and flagged registers
	localparam logic [7:0]  AEG_DDR_A   = 8'h04;
	localparam logic [7:0]  AEG_DDR_B   = 8'h05;
	localparam logic [7:0]  AEG_DDR_C   = 8'h06;
	localparam logic [7:0]  AEG_SYS_CTL = 8'h07;
	localparam logic [7:0]  AEG_TMR_CTL = 8'h09;
	localparam logic [7:0]  AEG_ADC_CTL = 8'h0E;

	typedef enum logic [9:0] {
		AEG_M_IMM  = 10'h001,
		AEG_M_DIR  = 10'h002,
		AEG_M_EXT  = 10'h004,
		AEG_M_REL  = 10'h008,
		AEG_M_IX0  = 10'h010,
		AEG_M_IX1  = 10'h020,
		AEG_M_IX2  = 10'h040,
		AEG_M_BSC  = 10'h080,
		AEG_M_BTB  = 10'h100,
		AEG_M_IMP  = 10'h200
	} aeg_mode_type;

	typedef enum logic [9:0] {
		AEG_S_IDLE = 10'h001,
		AEG_S_FET1 = 10'h002,
		AEG_S_CAP1 = 10'h004,
		AEG_S_FET2 = 10'h008,
		AEG_S_CAP2 = 10'h010,
		AEG_S_EVAL = 10'h020,
		AEG_S_BRD  = 10'h040,
		AEG_S_BCAP = 10'h080,
		AEG_S_BWR  = 10'h100,
		AEG_S_DONE = 10'h200
	} aeg_state_type;

endpackage

// File: logic/aeg_bit_unit.sv
// bit unit: forces or tests one selected bit of a byte
`timescale 1ns/1ps
`default_nettype none
module aeg_bit_unit (
	// operand
	input  wire logic [7:0] data_in,
	input  wire logic [2:0] bit_sel,
	input  wire logic       set_bit,
	// results
	output logic      [7:0] data_out,
	output logic            bit_val
);
	import aeg_pkg::*;

	// each bit passes through unless selected, then forced
	genvar i;
	generate
		for (i = 0; i < 8; i++) begin : g_bit
			assign data_out[i] = (bit_sel == 3'(i)) ? set_bit : data_in[i];
		end
	endgenerate

	// value of the selected bit for test and branch
	assign bit_val = data_in[bit_sel];
endmodule
`default_nettype wire

// File: logic/aeg_core.sv
// address generator: addressing mode decode, operand fetch, bit operations
`timescale 1ns/1ps
`default_nettype none
module aeg_core #(
	parameter logic [7:0] DDR_A_ADDR   = aeg_pkg::AEG_DDR_A,
	parameter logic [7:0] DDR_B_ADDR   = aeg_pkg::AEG_DDR_B,
	parameter logic [7:0] DDR_C_ADDR   = aeg_pkg::AEG_DDR_C,
	parameter logic [7:0] SYS_CTL_ADDR = aeg_pkg::AEG_SYS_CTL,
	parameter logic [7:0] TMR_CTL_ADDR = aeg_pkg::AEG_TMR_CTL,
	parameter logic [7:0] ADC_CTL_ADDR = aeg_pkg::AEG_ADC_CTL
) (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        sys_rst,
	// instruction from the decoder
	input  wire logic        start,
	input  wire logic [7:0]  opcode,
	input  wire logic [15:0] pc_in,
	input  wire logic [7:0]  index_x,
	input  wire logic        cond_true,
	// memory and i/o space
	output logic      [15:0] mem_addr,
	output logic             mem_rd,
	output logic             mem_wr,
	output logic      [7:0]  mem_wdata,
	input  wire logic [7:0]  mem_rdata,
	// results
	output logic             busy,
	output logic             done,
	output aeg_pkg::aeg_mode_type mode,
	output logic      [15:0] effective_address,
	output logic             addr_valid,
	output logic      [7:0]  operand,
	output logic      [1:0]  instr_len,
	output logic      [15:0] next_pc,
	output logic             carry_we,
	output logic             carry_val,
	output logic             ddr_skip,
	output logic             ctl_flag_hazard
);
	import aeg_pkg::*;

	typedef struct packed {
		aeg_state_type st;
		aeg_mode_type  mode;
		logic [7:0]    opc;
		logic [15:0]   pc;
		logic [7:0]    x;
		logic          cond;
		logic [7:0]    b1;
		logic [7:0]    b2;
		logic [15:0]   eff;
		logic          addr_vld;
		logic [15:0]   npc;
		logic [1:0]    len;
		logic [7:0]    opnd;
		logic          c_we;
		logic          c_val;
		logic [15:0]   maddr;
		logic          mrd;
		logic          mwr;
		logic [7:0]    mwd;
		logic          skip;
		logic          hazard;
	} aeg_regs_type;

	aeg_regs_type r_q;
	aeg_regs_type r_d;

	logic [7:0] mod_byte;
	logic       tested_bit;

	// bit forced or tested on the byte read back from page zero
	aeg_bit_unit u_bit (
		.data_in  (mem_rdata),
		.bit_sel  (r_q.opc[3:1]),
		.set_bit  (~r_q.opc[0]),
		.data_out (mod_byte),
		.bit_val  (tested_bit)
	);

	// opcode group to addressing mode
	function automatic aeg_mode_type mode_of(input logic [7:0] op);
		aeg_mode_type m;
		m = AEG_M_IMP;
		case (op[7:4])
			AEG_OP_BTB:   m = AEG_M_BTB;
			AEG_OP_BSC:   m = AEG_M_BSC;
			AEG_OP_REL:   m = AEG_M_REL;
			AEG_OP_DIRM:  m = AEG_M_DIR;
			AEG_OP_IDX1:  m = AEG_M_IX1;
			AEG_OP_IDX0:  m = AEG_M_IX0;
			AEG_OP_IMM:   m = (op == AEG_OP_BSR) ? AEG_M_REL : AEG_M_IMM;
			AEG_OP_DIR:   m = AEG_M_DIR;
			AEG_OP_EXT:   m = AEG_M_EXT;
			AEG_OP_IDX2:  m = AEG_M_IX2;
			AEG_OP_IDX1B: m = AEG_M_IX1;
			AEG_OP_IDX0B: m = AEG_M_IX0;
			default:      m = AEG_M_IMP;
		endcase
		return m;
	endfunction

	// instruction length per mode
	function automatic logic [1:0] len_of(input aeg_mode_type m);
		logic [1:0] l;
		l = AEG_LEN1;
		case (m)
			AEG_M_IMM: l = AEG_LEN2;
			AEG_M_DIR: l = AEG_LEN2;
			AEG_M_EXT: l = AEG_LEN3;
			AEG_M_REL: l = AEG_LEN2;
			AEG_M_IX0: l = AEG_LEN1;
			AEG_M_IX1: l = AEG_LEN2;
			AEG_M_IX2: l = AEG_LEN3;
			AEG_M_BSC: l = AEG_LEN2;
			AEG_M_BTB: l = AEG_LEN3;
			AEG_M_IMP: l = AEG_LEN1;
			default:   l = AEG_LEN1;
		endcase
		return l;
	endfunction

	logic [15:0] seq_pc;
	logic [15:0] rel_ext;
	logic [15:0] btb_ext;
	logic [15:0] addr_calc;
	logic        addr_has;
	logic        is_ddr;
	logic        is_ctl;
	logic        btb_taken;

	// address arithmetic; every sum wraps at 16 bits
	always_comb begin
		seq_pc  = 16'(r_q.pc + {14'h0000, r_q.len});
		rel_ext = {{8{r_q.b1[AEG_SIGN_BIT]}}, r_q.b1};
		btb_ext = {{8{r_q.b2[AEG_SIGN_BIT]}}, r_q.b2};
		addr_has  = 1'b1;
		addr_calc = 16'h0000;
		case (r_q.mode)
			AEG_M_IMM: addr_calc = 16'(r_q.pc + 16'h0001);
			AEG_M_DIR: addr_calc = {AEG_PAGE_ZERO, r_q.b1};
			AEG_M_EXT: addr_calc = {r_q.b1, r_q.b2};
			AEG_M_REL: addr_calc = 16'(r_q.pc + AEG_REL_BASE
				+ rel_ext);
			AEG_M_IX0: addr_calc = {AEG_PAGE_ZERO, r_q.x};
			AEG_M_IX1: addr_calc = {7'h00, {1'b0, r_q.b1}
				+ {1'b0, r_q.x}};
			AEG_M_IX2: addr_calc = 16'({r_q.b1, r_q.b2}
				+ {8'h00, r_q.x});
			AEG_M_BSC: addr_calc = {AEG_PAGE_ZERO, r_q.b1};
			AEG_M_BTB: addr_calc = {AEG_PAGE_ZERO, r_q.b1};
			AEG_M_IMP: addr_has  = 1'b0;
			default:   addr_has  = 1'b0;
		endcase
	end

	// page-zero targets that need special handling
	always_comb begin
		is_ddr = (r_q.b1 == DDR_A_ADDR) || (r_q.b1 == DDR_B_ADDR)
			|| (r_q.b1 == DDR_C_ADDR);
		is_ctl = (r_q.b1 == SYS_CTL_ADDR) || (r_q.b1 == TMR_CTL_ADDR)
			|| (r_q.b1 == ADC_CTL_ADDR);
		// even opcode branches on one, odd on zero
		btb_taken = (tested_bit == ~r_q.opc[0]);
	end

	// sequencer
	always_comb begin
		r_d     = r_q;
		r_d.mrd = 1'b0;
		r_d.mwr = 1'b0;
		case (r_q.st)
			AEG_S_IDLE: begin
				if (start) begin
					r_d.opc    = opcode;
					r_d.pc     = pc_in;
					r_d.x      = index_x;
					r_d.cond   = cond_true;
					r_d.mode   = mode_of(opcode);
					r_d.len    = len_of(mode_of(opcode));
					r_d.b1     = 8'h00;
					r_d.b2     = 8'h00;
					r_d.opnd   = 8'h00;
					r_d.addr_vld = 1'b0;
					r_d.c_we   = 1'b0;
					r_d.c_val  = 1'b0;
					r_d.skip   = 1'b0;
					r_d.hazard = 1'b0;
					if (len_of(mode_of(opcode)) == AEG_LEN1) begin
						r_d.st = AEG_S_EVAL;
					end else begin
						r_d.maddr = 16'(pc_in + 16'h0001);
						r_d.mrd   = 1'b1;
						r_d.st    = AEG_S_FET1;
					end
				end
			end
			AEG_S_FET1: begin
				r_d.st = AEG_S_CAP1;
			end
			AEG_S_CAP1: begin
				r_d.b1   = mem_rdata;
				r_d.opnd = mem_rdata;
				if (r_q.len == AEG_LEN3) begin
					r_d.maddr = 16'(r_q.pc + 16'h0002);
					r_d.mrd   = 1'b1;
					r_d.st    = AEG_S_FET2;
				end else begin
					r_d.st = AEG_S_EVAL;
				end
			end
			AEG_S_FET2: begin
				r_d.st = AEG_S_CAP2;
			end
			AEG_S_CAP2: begin
				r_d.b2 = mem_rdata;
				r_d.st = AEG_S_EVAL;
			end
			AEG_S_EVAL: begin
				r_d.eff      = addr_calc;
				r_d.addr_vld = addr_has;
				if (r_q.mode == AEG_M_REL) begin
					// not taken falls through with zero displacement
					r_d.npc = r_q.cond ? addr_calc : seq_pc;
				end else begin
					r_d.npc = seq_pc;
				end
				if ((r_q.mode == AEG_M_BSC) && is_ddr) begin
					r_d.skip = 1'b1;
					r_d.st   = AEG_S_DONE;
				end else if ((r_q.mode == AEG_M_BSC)
					|| (r_q.mode == AEG_M_BTB)) begin
					r_d.maddr = addr_calc;
					r_d.mrd   = 1'b1;
					r_d.st    = AEG_S_BRD;
				end else begin
					r_d.st = AEG_S_DONE;
				end
			end
			AEG_S_BRD: begin
				r_d.st = AEG_S_BCAP;
			end
			AEG_S_BCAP: begin
				r_d.opnd = mem_rdata;
				if (r_q.mode == AEG_M_BTB) begin
					r_d.c_we  = 1'b1;
					r_d.c_val = tested_bit;
					r_d.npc   = btb_taken
						? 16'(seq_pc + btb_ext) : seq_pc;
					r_d.st    = AEG_S_DONE;
				end else begin
					// write back the byte as read, one bit forced;
					// a flag set after the read is overwritten
					r_d.mwd    = mod_byte;
					r_d.hazard = is_ctl;
					r_d.mwr    = 1'b1;
					r_d.st     = AEG_S_BWR;
				end
			end
			AEG_S_BWR: begin
				r_d.st = AEG_S_DONE;
			end
			AEG_S_DONE: begin
				r_d.st = AEG_S_IDLE;
			end
			default: begin
				r_d.st = AEG_S_IDLE;
			end
		endcase
	end

	// state register
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			r_q        <= '0;
			r_q.st     <= AEG_S_IDLE;
			r_q.mode   <= AEG_M_IMP;
			r_q.len    <= AEG_LEN1;
		end else begin
			r_q <= r_d;
		end
	end

	// outputs
	assign mem_addr          = r_q.maddr;
	assign mem_rd            = r_q.mrd;
	assign mem_wr            = r_q.mwr;
	assign mem_wdata         = r_q.mwd;
	assign busy              = (r_q.st != AEG_S_IDLE);
	assign done              = (r_q.st == AEG_S_DONE);
	assign mode              = r_q.mode;
	assign effective_address = r_q.eff;
	assign addr_valid        = r_q.addr_vld;
	assign operand           = r_q.opnd;
	assign instr_len         = r_q.len;
	assign next_pc           = r_q.npc;
	assign carry_we          = r_q.c_we;
	assign carry_val         = r_q.c_val;
	assign ddr_skip          = r_q.skip;
	assign ctl_flag_hazard   = r_q.hazard;
endmodule
`default_nettype wire

// File: sim/aeg_mem_model.sv
// memory model: program bytes, page zero and i/o behind the generator
`timescale 1ns/1ps
`default_nettype none
module aeg_mem_model (
	// clock
	input  wire logic        clk,
	// access from the generator
	input  wire logic [15:0] mem_addr,
	input  wire logic        mem_rd,
	input  wire logic        mem_wr,
	input  wire logic [7:0]  mem_wdata,
	output logic      [7:0]  mem_rdata
);
	logic [7:0] mem [0:65535];
	initial mem_rdata = 8'h00;
	// read one cycle after the strobe; undriven data toggles
	always @(posedge clk) begin
		if (mem_wr) begin
			mem[mem_addr] <= mem_wdata;
		end
		mem_rdata <= mem_rd ? mem[mem_addr] : ~mem_rdata;
	end
endmodule
`default_nettype wire

// File: sim/aeg_core_asserts.sv
// checker: timing and address relations at the generator ports
`timescale 1ns/1ps
`default_nettype none
module aeg_core_asserts (
	// clock and reset
	input wire logic        clk,
	input wire logic        sys_rst,
	// request
	input wire logic        start,
	input wire logic [7:0]  opcode,
	input wire logic [15:0] pc_in,
	input wire logic [7:0]  index_x,
	input wire logic        cond_true,
	// memory and results
	input wire logic [15:0] mem_addr,
	input wire logic        mem_rd,
	input wire logic        mem_wr,
	input wire logic        busy,
	input wire logic        done,
	input wire aeg_pkg::aeg_mode_type mode,
	input wire logic [15:0] effective_address,
	input wire logic        addr_valid,
	input wire logic [1:0]  instr_len,
	input wire logic [15:0] next_pc,
	input wire logic        carry_we,
	input wire logic        ddr_skip
);
	import aeg_pkg::*;
	logic      go;
	logic [3:0] grp;
	assign go = start && !busy;
	assign grp = opcode[7:4];
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	a_imm_fetch: assert property (
		go && grp == AEG_OP_IMM && opcode != AEG_OP_BSR
		|=> mem_rd && mem_addr == $past(pc_in) + 16'h0001)
		else $error("immediate fetch address wrong");
	a_ext_timing: assert property (
		go && grp == AEG_OP_EXT |-> ##6 done && instr_len == AEG_LEN3)
		else $error("extended result wrong");
	a_dir_page: assert property (
		done && mode == AEG_M_DIR |-> effective_address[15:8] == 8'h00)
		else $error("direct address above page zero");
	a_rel_fall: assert property (
		go && grp == AEG_OP_REL && !cond_true
		|-> ##4 done && next_pc == $past(pc_in, 4) + AEG_REL_BASE)
		else $error("untaken branch does not fall through");
	a_ix0_addr: assert property (
		go && grp == AEG_OP_IDX0B |-> ##2 done
		&& effective_address == {8'h00, $past(index_x, 2)})
		else $error("indexed no offset address wrong");
	a_ix1_span: assert property (
		done && mode == AEG_M_IX1 |-> effective_address <= 16'h01FE)
		else $error("indexed offset sum out of span");
	a_btb_carry: assert property (
		go && grp == AEG_OP_BTB |-> ##8 done && carry_we
		&& instr_len == AEG_LEN3)
		else $error("bit test result wrong");
	a_bsc_write: assert property (
		done && mode == AEG_M_BSC |-> $past(mem_wr) != ddr_skip)
		else $error("bit set or clear write wrong");
	a_imp_no_addr: assert property (
		go && grp == 4'h9 |-> ##2 done && !addr_valid && mode == AEG_M_IMP)
		else $error("implied result wrong");
endmodule
bind aeg_core aeg_core_asserts i_chk (.clk, .sys_rst, .start, .opcode,
	.pc_in, .index_x, .cond_true, .mem_addr, .mem_rd, .mem_wr, .busy,
	.done, .mode, .effective_address, .addr_valid, .instr_len, .next_pc,
	.carry_we, .ddr_skip);
`default_nettype wire

// File: sim/tb_top.sv
// testbench: random and corner instructions through the generator
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import aeg_pkg::*;
	logic         clk;
	logic         sys_rst;
	logic         start;
	logic [7:0]   opcode;
	logic [15:0]  pc_in;
	logic [7:0]   index_x;
	logic         cond_true;
	logic [15:0]  mem_addr;
	logic         mem_rd;
	logic         mem_wr;
	logic [7:0]   mem_wdata;
	logic [7:0]   mem_rdata;
	logic         busy;
	logic         done;
	aeg_mode_type mode;
	logic [15:0]  effective_address;
	logic         addr_valid;
	logic [7:0]   operand;
	logic [1:0]   instr_len;
	logic [15:0]  next_pc;
	logic         carry_we;
	logic         carry_val;
	logic         ddr_skip;
	logic         ctl_flag_hazard;
	int           fail_count;
	int           check_count;
	aeg_core i_aeg_core (.clk, .sys_rst, .start, .opcode, .pc_in, .index_x,
		.cond_true, .mem_addr, .mem_rd, .mem_wr, .mem_wdata, .mem_rdata,
		.busy, .done, .mode, .effective_address, .addr_valid, .operand,
		.instr_len, .next_pc, .carry_we, .carry_val, .ddr_skip,
		.ctl_flag_hazard);
	aeg_mem_model i_mem (.clk, .mem_addr, .mem_rd, .mem_wr, .mem_wdata,
		.mem_rdata);
	// clock
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	// verdict and end of run
	task automatic wrap_up;
		if (fail_count == 0 && check_count > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	// compare one value
	task automatic check(input string nm, input logic [15:0] seen,
			input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// run one instruction and compare its results
	task automatic run(input logic [7:0] op, input logic [15:0] pc,
			input logic [7:0] x, input logic c, input logic [7:0] b1,
			input logic [7:0] b2);
		logic [15:0] exp_addr;
		logic [15:0] np;
		logic [7:0]  pz;
		logic [7:0]  wr;
		logic [9:0]  md;
		logic [1:0]  ln;
		logic        dd;
		int          n;
		pz = 8'($urandom);
		i_mem.mem[{8'h00, b1}] = pz;
		i_mem.mem[pc + 16'h0001] = b1;
		i_mem.mem[pc + 16'h0002] = b2;
		wr = pz;
		wr[op[3:1]] = !op[0];
		exp_addr = {8'h00, b1};
		ln = AEG_LEN2;
		md = AEG_M_DIR;
		case (op[7:4])
		4'h0: md = AEG_M_BTB;
		4'h1: md = AEG_M_BSC;
		4'h2: md = AEG_M_REL;
		4'h3, 4'hB: md = AEG_M_DIR;
		4'h6, 4'hE: md = AEG_M_IX1;
		4'h7, 4'hF: md = AEG_M_IX0;
		4'hA: md = (op == AEG_OP_BSR) ? AEG_M_REL : AEG_M_IMM;
		4'hC: md = AEG_M_EXT;
		4'hD: md = AEG_M_IX2;
		default: md = AEG_M_IMP;
		endcase
		if (md == AEG_M_IX1) exp_addr = exp_addr + {8'h00, x};
		if (md == AEG_M_IX0) exp_addr = {8'h00, x};
		if (md == AEG_M_IMM) exp_addr = pc + 16'h0001;
		if (md == AEG_M_EXT || md == AEG_M_IX2) exp_addr = {b1, b2};
		if (md == AEG_M_IX2) exp_addr = exp_addr + {8'h00, x};
		if (md == AEG_M_IX0 || md == AEG_M_IMP) ln = AEG_LEN1;
		if (md == AEG_M_EXT || md == AEG_M_IX2 || md == AEG_M_BTB) ln = AEG_LEN3;
		np = pc + {14'h0, ln};
		if (md == AEG_M_REL && c) np = np + {{8{b1[7]}}, b1};
		if (md == AEG_M_BTB && (pz[op[3:1]] ^ op[0])) np = np + {{8{b2[7]}}, b2};
		dd = md == AEG_M_BSC && (b1 == AEG_DDR_A || b1 == AEG_DDR_B
			|| b1 == AEG_DDR_C);
		@(negedge clk);
		{start, opcode, pc_in, index_x, cond_true} = {1'b1, op, pc, x, c};
		n = 0;
		@(negedge clk);
		while (done !== 1'b1 && n < 20) begin
			{start, opcode, pc_in, index_x} = {1'($urandom), 32'($urandom)};
			@(negedge clk);
			n++;
		end
		start = 1'b0;
		if (n == 20) begin
			check("done", 16'h0000, 16'h0001);
			wrap_up();
		end
		check("mode", {6'h00, mode}, {6'h00, md});
		check("len", {14'h0, instr_len}, {14'h0, ln});
		check("next_pc", next_pc, np);
		if (md != AEG_M_REL) check("addr_valid", {15'h0, addr_valid},
			{15'h0, md != AEG_M_IMP});
		if (md != AEG_M_REL && md != AEG_M_IMP) check("addr",
			effective_address, exp_addr);
		if (md == AEG_M_IMM) check("imm", {8'h00, operand}, {8'h00, b1});
		check("carry_we", {15'h0, carry_we}, {15'h0, md == AEG_M_BTB});
		if (md == AEG_M_BTB) check("carry", {15'h0, carry_val},
			{15'h0, pz[op[3:1]]});
		check("ddr_skip", {15'h0, ddr_skip}, {15'h0, dd});
		check("hazard", {15'h0, ctl_flag_hazard}, {15'h0, md == AEG_M_BSC
			&& (b1 == AEG_SYS_CTL || b1 == AEG_TMR_CTL
			|| b1 == AEG_ADC_CTL)});
		if (md == AEG_M_BSC) check("byte", {8'h00, i_mem.mem[{8'h00, b1}]},
			{8'h00, dd ? pz : wr});
		if (md == AEG_M_BSC && !dd) check("wdata", {8'h00, mem_wdata},
			{8'h00, wr});
		if (md == AEG_M_BTB || (md == AEG_M_BSC && !dd)) check("operand",
			{8'h00, operand}, {8'h00, pz});
	endtask
	// main sequence: reset, corners, then random instructions
	initial begin
		int          i;
		logic [7:0]  op;
		logic [7:0]  b1;
		fail_count = 0;
		check_count = 0;
		{sys_rst, start, opcode, pc_in, index_x, cond_true} = 35'h400000000;
		i = $urandom(32'h0031);
		repeat (16) @(negedge clk);
		sys_rst = 1'b0;
		check("reset_len", {14'h0, instr_len}, 16'h0001);
		check("reset_busy", {15'h0, busy}, 16'h0000);
		run(8'hD6, 16'hFFFC, 8'hFF, 1'b0, 8'hFF, 8'hFF);
		run(8'h20, 16'hFFFC, 8'h00, 1'b1, 8'h7F, 8'h00);
		run(8'h20, 16'h8100, 8'h00, 1'b1, 8'h80, 8'h00);
		run(8'hAD, 16'h9000, 8'h00, 1'b1, 8'hFE, 8'h00);
		run(8'h1E, 16'h9000, 8'h00, 1'b0, AEG_SYS_CTL, 8'h00);
		run(8'h13, 16'h9000, 8'h00, 1'b0, AEG_DDR_B, 8'h00);
		run(8'h0F, 16'h9000, 8'h00, 1'b0, 8'hC0, 8'h85);
		run(8'h00, 16'h9000, 8'h00, 1'b0, 8'h00, 8'h7E);
		for (i = 0; i < 600; i++) begin
			op = 8'($urandom);
			if (op == AEG_OP_BSR) op = 8'hA6;
			b1 = 8'($urandom);
			if (i % 4 == 0) b1 = {4'h0, 4'($urandom)};
			run(op, 16'h8000 + 16'($urandom % 32'h7FFD), 8'($urandom),
				1'($urandom), b1, 8'($urandom));
		end
		wrap_up();
	end
endmodule
`default_nettype wire
